// File: rtl/wdts_top.sv
// watchdog with selectable timeout, protected disable and axi4-lite slave
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module wdts_top (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic safety_level2,
    input wire logic dog_restart_instr,
    input wire logic irq_taken,
    output logic chip_reset_req,
    output logic dog_irq_req,
    output logic [15:0] dog_vector,
    output logic irq,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic tick;
    logic aw_hold_reg, w_hold_reg;
    logic [3:0] awaddr_reg;
    logic [7:0] wdata_reg;
    logic bvalid_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic irq_flag_reg, irq_en_reg, enable_reg, rst_flag_reg;
    logic [3:0] sel_reg;
    logic [2:0] unlock_cnt_reg;
    logic [1:0] st_reg, mask_reg;
    logic [20:0] cnt_reg;
    logic [20:0] cnt_next;
    logic rst_pend_reg;

    ////////////////////////////////////////////////////////////////////////
    // oscillator tick
    wdts_osc_div #(.DIV(wdts_pkg::DOG_DIV)) u_div (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    wire wr_go = aw_hold_reg && w_hold_reg && !bvalid_reg;
    wire wr_ctrl = wr_go && (awaddr_reg == wdts_pkg::OFS_CTRL);
    wire wr_cause = wr_go && (awaddr_reg == wdts_pkg::OFS_CAUSE);
    wire wr_stat = wr_go && (awaddr_reg == wdts_pkg::OFS_IRQ_STAT);
    wire wr_mask = wr_go && (awaddr_reg == wdts_pkg::OFS_IRQ_MASK);
    wire wr_hit = wr_ctrl || wr_cause || wr_stat || wr_mask;
    wire rd_go = s_axi_arvalid && !rvalid_reg;
    wire [3:0] rd_a = s_axi_araddr;
    wire rd_hit = rd_a == wdts_pkg::OFS_CTRL || rd_a == wdts_pkg::OFS_CAUSE
        || rd_a == wdts_pkg::OFS_IRQ_STAT || rd_a == wdts_pkg::OFS_IRQ_MASK;
    assign s_axi_awready = !aw_hold_reg;
    assign s_axi_wready = !w_hold_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;

    // written fields of the control register
    wire w_flag = wdata_reg[wdts_pkg::B_IRQ_FLAG];
    wire w_ie = wdata_reg[wdts_pkg::B_IRQ_EN];
    wire w_unl = wdata_reg[wdts_pkg::B_UNLOCK];
    wire w_en = wdata_reg[wdts_pkg::B_ENABLE];
    wire [3:0] w_sel = {wdata_reg[wdts_pkg::B_SEL3], wdata_reg[wdts_pkg::B_SEL2],
        wdata_reg[wdts_pkg::B_SEL1], wdata_reg[wdts_pkg::B_SEL0]};
    wire unlocked = unlock_cnt_reg != 3'h0;
    wire start_unl = wr_ctrl && w_unl && w_en;

    ////////////////////////////////////////////////////////////////////////
    // timeout control
    wire forced_en = !safety_level2 && rst_flag_reg;
    wire eff_en = safety_level2 || enable_reg || forced_en;
    wire running = eff_en || irq_en_reg;
    wire [3:0] eff_sel = (sel_reg > wdts_pkg::SEL_MAX) ? wdts_pkg::SEL_MAX : sel_reg;
    wire [20:0] limit = 21'((22'h1 << (wdts_pkg::BASE_CYCLES_LOG2 + 32'(eff_sel))) - 22'h1);
    wire expire = running && tick && (cnt_reg >= limit);
    wire to_irq = expire && irq_en_reg;
    wire to_rst = expire && !irq_en_reg && eff_en;
    assign cnt_next = (!running || dog_restart_instr || expire) ? 21'h0 :
        (tick ? cnt_reg + 21'h1 : cnt_reg);
    wire sel_ok = !safety_level2 || unlocked;
    wire en_next = start_unl ? 1'b1 : (wr_ctrl && (w_en || unlocked) ? w_en : enable_reg);
    wire ie_next = to_irq && eff_en ? 1'b0 : (wr_ctrl ? w_ie : irq_en_reg);

    // interrupt outputs
    // flag is only set in interrupt mode; request survives the enable clear
    assign dog_irq_req = irq_flag_reg;
    assign chip_reset_req = rst_pend_reg;
    assign dog_vector = rst_pend_reg ? wdts_pkg::VEC_RESET : wdts_pkg::VEC_DOG;
    assign irq = |(st_reg & mask_reg);
    ////////////////////////////////////////////////////////////////////////
    // bus channel state
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= 4'h0;
            wdata_reg <= 8'h00;
            bvalid_reg <= 1'b0;
            bresp_reg <= wdts_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_hold_reg) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr; // full offset, misaligned is refused
            end
            if (s_axi_wvalid && !w_hold_reg) begin
                w_hold_reg <= 1'b1;
                wdata_reg <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
            end
            if (wr_go) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_hit ? wdts_pkg::RESP_OKAY : wdts_pkg::RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // read data
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= wdts_pkg::RESP_OKAY;
        end else if (rd_go) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= rd_hit ? wdts_pkg::RESP_OKAY : wdts_pkg::RESP_SLVERR;
            unique case (rd_a)
                wdts_pkg::OFS_CTRL: rdata_reg <= {24'h0, irq_flag_reg, irq_en_reg, sel_reg[3],
                    unlocked, eff_en, sel_reg[2:0]};
                wdts_pkg::OFS_CAUSE: rdata_reg <= {28'h0, rst_flag_reg, 3'h0};
                wdts_pkg::OFS_IRQ_STAT: rdata_reg <= {30'h0, st_reg};
                wdts_pkg::OFS_IRQ_MASK: rdata_reg <= {30'h0, mask_reg};
                default: rdata_reg <= 32'h0; // unmapped reads return zero
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register and counter
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            enable_reg <= 1'b0;
            irq_en_reg <= 1'b0;
            sel_reg <= 4'h0;
            unlock_cnt_reg <= 3'h0;
            cnt_reg <= 21'h0;
        end else begin
            enable_reg <= en_next;
            irq_en_reg <= ie_next;
            cnt_reg <= cnt_next;
            if (wr_ctrl && !start_unl && sel_ok) begin
                sel_reg <= w_sel;
            end
            if (start_unl) begin
                unlock_cnt_reg <= 3'(wdts_pkg::UNLOCK_CYCLES);
            end else if (unlocked) begin
                unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
            end
        end
    end

    // flags: hardware set wins over software clear
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irq_flag_reg <= 1'b0;
            rst_flag_reg <= 1'b0;
            rst_pend_reg <= 1'b0;
            st_reg <= 2'b00;
            mask_reg <= 2'b00;
        end else begin
            rst_pend_reg <= to_rst;
            if (to_irq) begin
                irq_flag_reg <= 1'b1;
            end else if ((wr_ctrl && w_flag) || irq_taken) begin
                irq_flag_reg <= 1'b0;
            end
            if (to_rst) begin
                rst_flag_reg <= 1'b1;
            end else if (wr_cause && !wdata_reg[wdts_pkg::B_DOG_RST]) begin
                rst_flag_reg <= 1'b0;
            end
            st_reg[wdts_pkg::B_ST_TIMEOUT] <= to_irq || (st_reg[wdts_pkg::B_ST_TIMEOUT]
                && !(wr_stat && wdata_reg[wdts_pkg::B_ST_TIMEOUT]));
            st_reg[wdts_pkg::B_ST_RESET] <= to_rst || (st_reg[wdts_pkg::B_ST_RESET]
                && !(wr_stat && wdata_reg[wdts_pkg::B_ST_RESET]));
            if (wr_mask) begin
                mask_reg <= wdata_reg[1:0];
            end
        end
    end
endmodule : wdts_top

// File: pkg/wdts_pkg.sv
// package: watchdog register map, field positions, timing constants
package wdts_pkg;
    // axi4-lite byte offsets
    localparam logic [3:0] OFS_CTRL = 4'h0; // dog_ctrl_reg
    localparam logic [3:0] OFS_CAUSE = 4'h4; // reset_cause_reg
    localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
    localparam logic [3:0] OFS_IRQ_MASK = 4'hC;
    // dog_ctrl_reg fields
    localparam int B_IRQ_FLAG = 7;
    localparam int B_IRQ_EN = 6;
    localparam int B_SEL3 = 5;
    localparam int B_UNLOCK = 4;
    localparam int B_ENABLE = 3;
    localparam int B_SEL2 = 2;
    localparam int B_SEL1 = 1;
    localparam int B_SEL0 = 0;
    // reset_cause_reg field
    localparam int B_DOG_RST = 3;
    // irq status fields
    localparam int B_ST_TIMEOUT = 0;
    localparam int B_ST_RESET = 1;
    // vectors
    localparam logic [15:0] VEC_RESET = 16'h0000;
    localparam logic [15:0] VEC_DOG = 16'h0004;
    // timing
    localparam int SYS_CLK_KHZ = 125000;
    localparam int DOG_OSC_KHZ = 128;
    localparam int DOG_DIV = SYS_CLK_KHZ / DOG_OSC_KHZ; // rounded down
    localparam int UNLOCK_CYCLES = 4;
    localparam logic [3:0] SEL_MAX = 4'h9;
    localparam int BASE_CYCLES_LOG2 = 11; // 2k cycles
    localparam int CNT_W = 21;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : wdts_pkg

// File: rtl/wdts_osc_div.sv
// divider: one-cycle tick at the watchdog oscillator rate
`timescale 1ns/1ns
module wdts_osc_div #(
    parameter int DIV = 976
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    output logic tick
);
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic wrap;

    // count down and pulse at wrap
    assign wrap = (cnt_reg == 16'h0000);
    assign cnt_next = wrap ? 16'(DIV - 1) : cnt_reg - 16'h0001;
    assign tick = wrap;

    // counter register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= 16'h0000;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule : wdts_osc_div

// File: bench/wdts_top_chk.sv
// checker: watchdog outputs and register bus answers
`timescale 1ns/1ns
module wdts_top_chk (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic dog_restart_instr,
    input wire logic chip_reset_req,
    input wire logic dog_irq_req,
    input wire logic [15:0] dog_vector,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // shortest legal timeout, one tick of slack for divider phase
    localparam int MIN_GAP = 2047 * wdts_pkg::DOG_DIV;
    logic [21:0] gap_reg;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // cycles since reset, restart or the last timeout event
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) gap_reg <= '0;
        else if (dog_restart_instr || chip_reset_req || $rose(dog_irq_req)) gap_reg <= '0;
        else if (gap_reg != '1) gap_reg <= gap_reg + 22'h1;
    end
    property p_rst_pulse; chip_reset_req |=> !chip_reset_req; endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("reset request longer than one cycle");
    property p_rst_vec; chip_reset_req |-> dog_vector == wdts_pkg::VEC_RESET; endproperty
    a_rst_vec: assert property (p_rst_vec) else $error("wrong vector with reset request");
    property p_irq_vec; !chip_reset_req |-> dog_vector == wdts_pkg::VEC_DOG; endproperty
    a_irq_vec: assert property (p_irq_vec) else $error("wrong timeout vector");
    property p_min_timeout; ($rose(dog_irq_req) || chip_reset_req) |-> gap_reg >= MIN_GAP; endproperty
    a_min_timeout: assert property (p_min_timeout) else $error("timeout before shortest period");
    property p_bone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_bone: assert property (p_bone) else $error("write response repeated");
    property p_rone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_rone: assert property (p_rone) else $error("read data repeated");
    property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rlat: assert property (p_rlat) else $error("read answer late");
    property p_rcause; $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready); endproperty
    a_rcause: assert property (p_rcause) else $error("read answer without request");
endmodule : wdts_top_chk
bind wdts_top wdts_top_chk u_chk (.clk_sys, .arst_n, .dog_restart_instr, .chip_reset_req, .dog_irq_req,
    .dog_vector, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);

// File: bench/wdts_top_tb.sv
// testbench: register access, selector codes and timed disable
`timescale 1ns/1ns
module wdts_top_tb;
    logic clk_sys = 1'b0, arst_n = 1'b0, safety_level2 = 1'b0, dog_restart_instr = 1'b0, irq_taken = 1'b0;
    logic chip_reset_req, dog_irq_req, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF, sel;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [15:0] dog_vector;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int err_total = 0, check_count = 0, tick_cnt = 0, i;
    localparam logic [1:0] OK = wdts_pkg::RESP_OKAY;
    localparam logic [3:0] CT = wdts_pkg::OFS_CTRL;
    wdts_top dut (.*);
    always #4 clk_sys = ~clk_sys;
    // count oscillator ticks inside the design
    always @(posedge clk_sys) if (dut.tick === 1'b1) tick_cnt++;
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out
    // axi write, entered just after a rising edge
    task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] r;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= v;
        s_axi_wvalid <= 1'b1;
        tb = 1'b0;
        for (int n = 0; n < 40 && !tb; n++) begin
            @(negedge clk_sys);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk_sys);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        chk({31'h0, tb}, 32'h1);
        chk({30'h0, r}, {30'h0, er});
    endtask : wr
    // axi read, entered just after a rising edge
    task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic ta, tb;
        logic [1:0] r;
        logic [31:0] v;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        tb = 1'b0;
        for (int n = 0; n < 40 && !tb; n++) begin
            @(negedge clk_sys);
            ta = s_axi_arvalid && s_axi_arready;
            tb = s_axi_rvalid;
            v = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk_sys);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        chk({31'h0, tb}, 32'h1);
        chk(v, exp);
        chk({30'h0, r}, {30'h0, er});
    endtask : rd
    ////////////////////////////////////////////////////////////////
    // hang guard
    initial begin
        #(8 * 5000);
        err_total++;
        close_out();
    end
    // main sequence
    initial begin
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        chk({16'h0, dog_vector}, {16'h0, wdts_pkg::VEC_DOG});
        chk({29'h0, chip_reset_req, dog_irq_req, irq}, 32'h0);
        for (i = 0; i < 4; i++) rd(4'(4 * i), 32'h0, OK);
        for (i = 0; i < 10; i++) begin
            sel = 4'(i);
            d = {26'h0, sel[3], 2'b00, sel[2:0]};
            wr(CT, d, OK);
            rd(CT, d, OK);
        end
        wr(CT, 32'h00, OK);
        wr(CT, 32'h08, OK);
        wr(CT, 32'h00, OK);
        rd(CT, 32'h08, OK);
        wr(wdts_pkg::OFS_CAUSE, 32'h0, OK);
        wr(CT, 32'h18, OK);
        wr(CT, 32'h00, OK);
        rd(CT, 32'h00, OK);
        wr(CT, 32'h08, OK);
        wr(CT, 32'h18, OK);
        repeat (8) @(posedge clk_sys);
        rd(CT, 32'h08, OK);
        wr(CT, 32'h00, OK);
        rd(CT, 32'h08, OK);
        wr(CT, 32'h18, OK);
        wr(CT, 32'h00, OK);
        rd(CT, 32'h00, OK);
        wr(wdts_pkg::OFS_CAUSE, 32'h0, OK);
        rd(wdts_pkg::OFS_CAUSE, 32'h0, OK);
        wr(wdts_pkg::OFS_IRQ_MASK, 32'h3, OK);
        rd(wdts_pkg::OFS_IRQ_MASK, 32'h3, OK);
        wr(wdts_pkg::OFS_IRQ_STAT, 32'h3, OK);
        rd(wdts_pkg::OFS_IRQ_STAT, 32'h0, OK);
        chk({31'h0, irq}, 32'h0);
        wr(4'h2, 32'hFF, wdts_pkg::RESP_SLVERR);
        rd(4'h2, 32'h0, wdts_pkg::RESP_SLVERR);
        dog_restart_instr <= 1'b1;
        irq_taken <= 1'b1;
        safety_level2 <= 1'b1;
        @(posedge clk_sys);
        dog_restart_instr <= 1'b0;
        irq_taken <= 1'b0;
        rd(CT, 32'h08, OK);
        wr(CT, 32'h18, OK);
        wr(CT, 32'h00, OK);
        rd(CT, 32'h08, OK);
        wr(CT, 32'h01, OK);
        rd(CT, 32'h08, OK);
        wr(CT, 32'h18, OK);
        wr(CT, 32'h01, OK);
        rd(CT, 32'h09, OK);
        // two full oscillator periods between two falling edges
        @(negedge clk_sys);
        tick_cnt = 0;
        repeat (2 * wdts_pkg::DOG_DIV) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(32'(tick_cnt), 32'd2);
        close_out();
    end
endmodule : wdts_top_tb
